// >>> register_transfer_instr_decode_bench.sv
module register_transfer_instr_decode_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rst_b = 0;
  logic [9:0] instr_word = 10'h000;
  logic instr_valid = 0;
  logic wb_cyc_i = 0;
  logic wb_stb_i = 0;
  logic wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, instr_done, skip_req;
  logic [3:0] acc, b_reg;
  logic [2:0] d_reg_bits;
  logic [31:0] q;
  logic done;
  int err_count = 0;
  int num_checks = 0;
  int tick = 0;
  xfer_exec dut_u (.clk(clk), .rst_b(rst_b), .instr_word(instr_word), .instr_valid(instr_valid),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .acc(acc), .b_reg(b_reg), .d_reg_bits(d_reg_bits), .instr_done(instr_done),
    .skip_req(skip_req));
  initial begin
    forever #50 clk = ~clk;
  end
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'hf};
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask : wb
  task automatic exec(input logic [9:0] op);
    @(posedge clk);
    instr_word <= op;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1 done = instr_done;
  endtask : exec
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_loads;
    logic [7:0] offs [5] = '{xfer_pkg::off_w4, xfer_pkg::off_w5, xfer_pkg::off_w6,
      xfer_pkg::off_x, xfer_pkg::off_y};
    logic [9:0] ops [5] = '{xfer_pkg::op_read_timer_ctrl_4, xfer_pkg::op_read_timer_ctrl_5,
      xfer_pkg::op_read_timer_ctrl_6, xfer_pkg::op_ptr_low_to_acc, xfer_pkg::op_ptr_y_to_acc};
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, offs[i], 32'(i + 9));
      exec(ops[i]);
      chk("acc", 32'(i + 9), {28'h0, acc});
      chk("done", 32'h1, {31'h0, done});
    end
    $display("test loads done");
  endtask : t_loads
  task automatic t_bank;
    wb(1'b1, xfer_pkg::off_z, 32'hfffffffe);
    wb(1'b1, xfer_pkg::off_acc, 32'hf);
    exec(xfer_pkg::op_bank_ptr_to_acc);
    chk("acc", 32'h2, {28'h0, acc});
    $display("test bank done");
  endtask : t_bank
  task automatic t_b_d;
    wb(1'b1, xfer_pkg::off_acc, 32'hd);
    exec(xfer_pkg::op_acc_to_b);
    chk("b_reg", 32'hd, {28'h0, b_reg});
    chk("acc", 32'hd, {28'h0, acc});
    exec(xfer_pkg::op_acc_to_d);
    chk("d_reg_bits", 32'h5, {29'h0, d_reg_bits});
    wb(1'b0, xfer_pkg::off_b, 32'h0);
    chk("b read", 32'hd, q);
    $display("test b d done");
  endtask : t_b_d
  task automatic t_other;
    exec(10'h3ff);
    chk("done", 32'h0, {31'h0, done});
    chk("acc", 32'hd, {28'h0, acc});
    chk("b_reg", 32'hd, {28'h0, b_reg});
    chk("d_reg_bits", 32'h5, {29'h0, d_reg_bits});
    chk("skip", 32'h0, {31'h0, skip_req});
    wb(1'b0, xfer_pkg::off_status, 32'h0);
    chk("status", {14'h0, xfer_pkg::op_acc_to_d, 8'h08}, q);
    wb(1'b0, 8'h3c, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test other done");
  endtask : t_other
  // ---------------------------------------------------------------
  // run control
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    tick++;
    if (tick == 3000) begin
      err_count++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_loads();
    t_bank();
    t_b_d();
    t_other();
    conclude();
  end
endmodule : register_transfer_instr_decode_bench

// >>> xfer_dec_if.sv
interface xfer_dec_if;
  logic [9:0] instr;
  logic valid;
  logic sel_w4;
  logic sel_w5;
  logic sel_w6;
  logic sel_x;
  logic sel_y;
  logic sel_z;
  logic sel_b;
  logic sel_d;
  logic hit;

  modport decoder (input instr, input valid, output sel_w4, output sel_w5, output sel_w6,
    output sel_x, output sel_y, output sel_z, output sel_b, output sel_d, output hit);
  modport exec (output instr, output valid, input sel_w4, input sel_w5, input sel_w6,
    input sel_x, input sel_y, input sel_z, input sel_b, input sel_d, input hit);
endinterface : xfer_dec_if

// >>> xfer_exec.sv
// Functional notes
// - opcode 0x24E loads accumulator from timer control 4
// - opcode 0x24F loads accumulator from timer control 5
// - opcode 0x250 loads accumulator from timer control 6
// - opcode 0x052 loads accumulator from pointer X
// - opcode 0x01F loads accumulator from pointer Y
// - bank pointer into acc bits 1:0, upper zero
// - accumulator copied into B, accumulator kept
// - opcode 0x029 copies acc bits 2:0 into D
module xfer_exec (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [9:0] instr_word,
  input wire logic instr_valid,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [3:0] acc,
  output logic [3:0] b_reg,
  output logic [2:0] d_reg_bits,
  output logic instr_done,
  output logic skip_req
);
  // ---------------------------------------------------------------
  // decoder hookup
  // ---------------------------------------------------------------
  xfer_dec_if dec ();

  assign dec.instr = instr_word;
  assign dec.valid = instr_valid;

  xfer_opcode_dec u_dec (
    .dec(dec)
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [3:0] acc_ff;
  logic [3:0] b_ff;
  logic [2:0] d_ff;
  logic [3:0] x_ff;
  logic [3:0] y_ff;
  logic [1:0] z_ff;
  logic [3:0] timer_ctrl_reg_4_ff;
  logic [3:0] timer_ctrl_reg_5_ff;
  logic [3:0] timer_ctrl_reg_6_ff;
  logic [7:0] cnt_ff;
  logic [9:0] last_ff;
  logic done_ff;
  logic skip_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  wire req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire [3:0] wnib = wb_dat_i[3:0];
  wire a_acc = (wb_adr_i == xfer_pkg::off_acc);
  wire a_b = (wb_adr_i == xfer_pkg::off_b);
  wire a_d = (wb_adr_i == xfer_pkg::off_d);
  wire a_x = (wb_adr_i == xfer_pkg::off_x);
  wire a_y = (wb_adr_i == xfer_pkg::off_y);
  wire a_z = (wb_adr_i == xfer_pkg::off_z);
  wire a_w4 = (wb_adr_i == xfer_pkg::off_w4);
  wire a_w5 = (wb_adr_i == xfer_pkg::off_w5);
  wire a_w6 = (wb_adr_i == xfer_pkg::off_w6);
  wire a_st = (wb_adr_i == xfer_pkg::off_status);

  // ---------------------------------------------------------------
  // accumulator source select
  // ---------------------------------------------------------------
  wire acc_load = dec.sel_w4 | dec.sel_w5 | dec.sel_w6 | dec.sel_x | dec.sel_y | dec.sel_z;
  wire [3:0] acc_src =
    dec.sel_w4 ? timer_ctrl_reg_4_ff :
    dec.sel_w5 ? timer_ctrl_reg_5_ff :
    dec.sel_w6 ? timer_ctrl_reg_6_ff :
    dec.sel_x ? x_ff :
    dec.sel_y ? y_ff :
    {2'h0, z_ff};

  // instruction beats a same-cycle bus write to the same register
  wire [3:0] nxt_acc = acc_load ? acc_src : ((wr & a_acc) ? wnib : acc_ff);
  wire [3:0] nxt_b = dec.sel_b ? acc_ff : ((wr & a_b) ? wnib : b_ff);
  wire [2:0] nxt_d = dec.sel_d ? acc_ff[2:0] : ((wr & a_d) ? wnib[2:0] : d_ff);
  wire [7:0] nxt_cnt = dec.hit ? cnt_ff + 8'h01 : cnt_ff;
  wire [9:0] nxt_last = dec.hit ? instr_word : last_ff;

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [31:0] status_word = {14'h0000, last_ff, cnt_ff};
  wire [31:0] rd_mux =
    a_acc ? {28'h0000000, acc_ff} :
    a_b ? {28'h0000000, b_ff} :
    a_d ? {29'h00000000, d_ff} :
    a_x ? {28'h0000000, x_ff} :
    a_y ? {28'h0000000, y_ff} :
    a_z ? {30'h00000000, z_ff} :
    a_w4 ? {28'h0000000, timer_ctrl_reg_4_ff} :
    a_w5 ? {28'h0000000, timer_ctrl_reg_5_ff} :
    a_w6 ? {28'h0000000, timer_ctrl_reg_6_ff} :
    a_st ? status_word :
    32'h00000000;
  wire [31:0] nxt_rdat = (req & ~wb_we_i) ? rd_mux : 32'h00000000;

  // ---------------------------------------------------------------
  // execution registers
  // ---------------------------------------------------------------
  // every decoded word finishes in this single edge
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_ff <= xfer_pkg::rst_nib;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      b_ff <= xfer_pkg::rst_nib;
    end else begin
      b_ff <= nxt_b;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      d_ff <= xfer_pkg::rst_d;
    end else begin
      d_ff <= nxt_d;
    end
  end

  // ---------------------------------------------------------------
  // source registers, software loaded
  // ---------------------------------------------------------------
  wire [3:0] nxt_x = (wr & a_x) ? wnib : x_ff;
  wire [3:0] nxt_y = (wr & a_y) ? wnib : y_ff;
  wire [1:0] nxt_z = (wr & a_z) ? wnib[1:0] : z_ff;
  wire [3:0] nxt_w4 = (wr & a_w4) ? wnib : timer_ctrl_reg_4_ff;
  wire [3:0] nxt_w5 = (wr & a_w5) ? wnib : timer_ctrl_reg_5_ff;
  wire [3:0] nxt_w6 = (wr & a_w6) ? wnib : timer_ctrl_reg_6_ff;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      x_ff <= xfer_pkg::rst_nib;
    end else begin
      x_ff <= nxt_x;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      y_ff <= xfer_pkg::rst_nib;
    end else begin
      y_ff <= nxt_y;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      z_ff <= xfer_pkg::rst_z;
    end else begin
      z_ff <= nxt_z;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_ctrl_reg_4_ff <= xfer_pkg::rst_nib;
    end else begin
      timer_ctrl_reg_4_ff <= nxt_w4;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_ctrl_reg_5_ff <= xfer_pkg::rst_nib;
    end else begin
      timer_ctrl_reg_5_ff <= nxt_w5;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      timer_ctrl_reg_6_ff <= xfer_pkg::rst_nib;
    end else begin
      timer_ctrl_reg_6_ff <= nxt_w6;
    end
  end

  // ---------------------------------------------------------------
  // status and completion
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= xfer_pkg::rst_cnt;
      last_ff <= 10'h000;
      done_ff <= 1'b0;
      skip_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      last_ff <= nxt_last;
      done_ff <= dec.hit;
      skip_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // wishbone answer
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff <= req;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign acc = acc_ff;
  assign b_reg = b_ff;
  assign d_reg_bits = d_ff;
  assign instr_done = done_ff;
  assign skip_req = skip_ff;
endmodule : xfer_exec

// >>> xfer_exec_assertions.sv
module xfer_exec_assertions (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [9:0] instr_word,
  input wire logic instr_valid,
  input wire logic wb_cyc_i,
  input wire logic [3:0] acc,
  input wire logic [3:0] b_reg,
  input wire logic [2:0] d_reg_bits,
  input wire logic instr_done,
  input wire logic skip_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire logic [2:0] acc_lo = acc[2:0];
  wire logic is_b = instr_valid && instr_word == xfer_pkg::op_acc_to_b;
  wire logic is_d = instr_valid && instr_word == xfer_pkg::op_acc_to_d;
  wire logic is_z = instr_valid && instr_word == xfer_pkg::op_bank_ptr_to_acc;
  wire logic hit = instr_valid && (instr_word inside {xfer_pkg::op_read_timer_ctrl_4,
    xfer_pkg::op_read_timer_ctrl_5, xfer_pkg::op_read_timer_ctrl_6, xfer_pkg::op_ptr_low_to_acc,
    xfer_pkg::op_ptr_y_to_acc, xfer_pkg::op_bank_ptr_to_acc, xfer_pkg::op_acc_to_b,
    xfer_pkg::op_acc_to_d});
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  property p_b_copy; is_b |=> b_reg == $past(acc); endproperty
  a_b_copy: assert property (p_b_copy) else $error("b not loaded from acc");
  property p_b_keep; is_b && !wb_cyc_i |=> $stable(acc); endproperty
  a_b_keep: assert property (p_b_keep) else $error("acc changed by b copy");
  property p_d_copy; is_d |=> d_reg_bits == $past(acc_lo); endproperty
  a_d_copy: assert property (p_d_copy) else $error("d not loaded from acc");
  property p_z_upper; is_z |=> acc[3:2] == 2'h0; endproperty
  a_z_upper: assert property (p_z_upper) else $error("acc upper bits not zero");
  property p_done; hit |=> instr_done; endproperty
  a_done: assert property (p_done) else $error("no done after one cycle");
  property p_no_skip; !skip_req; endproperty
  a_no_skip: assert property (p_no_skip) else $error("skip requested");
  property p_done_cause; !hit |=> !instr_done; endproperty
  a_done_cause: assert property (p_done_cause) else $error("done without opcode");
  property p_keep;
    instr_valid && !hit && !wb_cyc_i |=> $stable(acc) && $stable(b_reg) && $stable(d_reg_bits);
  endproperty
  a_keep: assert property (p_keep) else $error("unmatched word changed state");
endmodule : xfer_exec_assertions

bind xfer_exec xfer_exec_assertions chk_u (.clk(clk), .rst_b(rst_b), .instr_word(instr_word),
  .instr_valid(instr_valid), .wb_cyc_i(wb_cyc_i), .acc(acc), .b_reg(b_reg),
  .d_reg_bits(d_reg_bits), .instr_done(instr_done), .skip_req(skip_req));

// >>> xfer_opcode_dec.sv
module xfer_opcode_dec (
  xfer_dec_if.decoder dec
);
  // ---------------------------------------------------------------
  // one-hot opcode match, qualified by valid
  // ---------------------------------------------------------------
  wire m_w4 = (dec.instr == xfer_pkg::op_read_timer_ctrl_4);
  wire m_w5 = (dec.instr == xfer_pkg::op_read_timer_ctrl_5);
  wire m_w6 = (dec.instr == xfer_pkg::op_read_timer_ctrl_6);
  wire m_x = (dec.instr == xfer_pkg::op_ptr_low_to_acc);
  wire m_y = (dec.instr == xfer_pkg::op_ptr_y_to_acc);
  wire m_z = (dec.instr == xfer_pkg::op_bank_ptr_to_acc);
  wire m_b = (dec.instr == xfer_pkg::op_acc_to_b);
  wire m_d = (dec.instr == xfer_pkg::op_acc_to_d);

  assign dec.sel_w4 = dec.valid & m_w4;
  assign dec.sel_w5 = dec.valid & m_w5;
  assign dec.sel_w6 = dec.valid & m_w6;
  assign dec.sel_x = dec.valid & m_x;
  assign dec.sel_y = dec.valid & m_y;
  assign dec.sel_z = dec.valid & m_z;
  assign dec.sel_b = dec.valid & m_b;
  assign dec.sel_d = dec.valid & m_d;
  // unmatched words raise no select at all
  assign dec.hit = dec.sel_w4 | dec.sel_w5 | dec.sel_w6 | dec.sel_x | dec.sel_y
    | dec.sel_z | dec.sel_b | dec.sel_d;
endmodule : xfer_opcode_dec

// >>> xfer_pkg.sv
package xfer_pkg;
  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int unsigned instr_w = 10;
  localparam int unsigned acc_w = 4;
  localparam int unsigned d_w = 3;
  localparam int unsigned z_w = 2;
  localparam int unsigned adr_w = 8;
  localparam int unsigned dat_w = 32;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [9:0] op_read_timer_ctrl_4 = 10'h24e;
  localparam logic [9:0] op_read_timer_ctrl_5 = 10'h24f;
  localparam logic [9:0] op_read_timer_ctrl_6 = 10'h250;
  localparam logic [9:0] op_ptr_low_to_acc = 10'h052;
  localparam logic [9:0] op_ptr_y_to_acc = 10'h01f;
  localparam logic [9:0] op_bank_ptr_to_acc = 10'h053;
  localparam logic [9:0] op_acc_to_b = 10'h00e;
  localparam logic [9:0] op_acc_to_d = 10'h029;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] off_acc = 8'h00;
  localparam logic [7:0] off_b = 8'h04;
  localparam logic [7:0] off_d = 8'h08;
  localparam logic [7:0] off_x = 8'h0c;
  localparam logic [7:0] off_y = 8'h10;
  localparam logic [7:0] off_z = 8'h14;
  localparam logic [7:0] off_w4 = 8'h18;
  localparam logic [7:0] off_w5 = 8'h1c;
  localparam logic [7:0] off_w6 = 8'h20;
  localparam logic [7:0] off_status = 8'h24;

  // ---------------------------------------------------------------
  // reset values and status fields
  // ---------------------------------------------------------------
  localparam logic [3:0] rst_nib = 4'h0;
  localparam logic [2:0] rst_d = 3'h0;
  localparam logic [1:0] rst_z = 2'h0;
  localparam logic [7:0] rst_cnt = 8'h00;
  localparam int unsigned st_cnt_lsb = 0;
  localparam int unsigned st_cnt_msb = 7;
  localparam int unsigned st_last_lsb = 8;
  localparam int unsigned st_last_msb = 17;
endpackage : xfer_pkg
